// ---- core/bkrc_regs.svh ----
/*
 Constants for the step-down regulator control block: channel count,
 code widths, field values and timing counts.
 Assumes a 20 MHz core clock and inclusion by bare name.
*/
`ifndef BKRC_REGS_SVH
`define BKRC_REGS_SVH

// ==================================================
// Sizes
`define BKRC_NCH 4
`define BKRC_CW 8
`define BKRC_STEP_W 4
`define BKRC_CODE_ZERO 8'h00
// Step size per code in millivolts
`define BKRC_STEP_MV_STD 8'h0a
`define BKRC_STEP_MV_THIRD 8'h14
`define BKRC_THIRD_IDX 2
// ==================================================
// Operating mode field values
`define BKRC_MODE_AUTO 2'h0
`define BKRC_MODE_SLEEP 2'h1
`define BKRC_MODE_SYNC 2'h2
// ==================================================
// Timing: base step time 1 us at 20 MHz, 1 ms start-up
`define BKRC_CLK_MHZ 20
`define BKRC_BASE_NS 1000
`define BKRC_BASE_CYC (`BKRC_BASE_NS * `BKRC_CLK_MHZ / 1000)
`define BKRC_BASE_W 5
`define BKRC_SS_US 1000
`define BKRC_FAST_STEP 4'h0
`define BKRC_SLOW_STEP 4'h4
`endif

// ---- core/bkrc_pkg.sv ----
/*
 Types for the step-down regulator control block.
 Assumes bkrc_regs.svh is compiled alongside.
*/
package bkrc_pkg;
    // Power mode, one-hot
    typedef enum logic [3:0] {
        BKRC_NOPWR = 4'h1,
        BKRC_RESET = 4'h2,
        BKRC_ON = 4'h4,
        BKRC_CLKMODE = 4'h8
    } bkrc_pmode_t;
endpackage

// ---- core/bkrc_tick.sv ----
/*
 Step-time tick divider: one-cycle pulse every (step+1) base periods.
 Assumes a single core clock and asynchronous high reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "bkrc_regs.svh"
module bkrc_tick
    import bkrc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [`BKRC_STEP_W-1:0] i_step_time,
    output logic o_tick
);
    // ==================================================
    // Base period counter
    logic [`BKRC_BASE_W-1:0] base_reg;
    logic [`BKRC_STEP_W-1:0] mult_reg;
    logic base_hit;
    assign base_hit = (base_reg == `BKRC_BASE_W'(`BKRC_BASE_CYC - 1));
    // Base divider
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            base_reg <= '0;
        end else if (base_hit) begin
            base_reg <= '0;
        end else begin
            base_reg <= base_reg + `BKRC_BASE_W'(1);
        end
    end
    // Step multiplier, tick pulses come from a flop
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mult_reg <= '0;
            o_tick <= 1'b0;
        end else begin
            o_tick <= 1'b0;
            if (base_hit) begin
                if (mult_reg >= i_step_time) begin
                    mult_reg <= '0;
                    o_tick <= 1'b1;
                end else begin
                    mult_reg <= mult_reg + `BKRC_STEP_W'(1);
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- core/bkrc_sync.sv ----
/*
 Two-flop level synchroniser for pins of the block, vector wide.
 Assumes the input is asynchronous to the core clock.
*/
`timescale 1ns/1ns
`default_nettype none
module bkrc_sync #(
    parameter int W = 1
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    // ==================================================
    // First stage is read only by the second
    logic [W-1:0] meta_reg;
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_reg <= '0;
            o_sync <= '0;
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ---- core/bkrc_top.sv ----
/*
 Control for four step-down regulators: enables, A/B settings, stepped
 ramping with a ready event, start-up and discharge, mode and current
 controls, dual-phase merge, termination mode and the power modes.
 Assumes the analog stages consume the outputs; pins arrive async.
*/
// What this block does
// - Code steps 10 mV, third regulator 20 mV
// - Enable from bit, input pin or sequencer
// - Two settings, picked by bit, pin, mode
// - Ramp through every intermediate code
// - One step time shared by all regulators
// - Ready event once all reach target
// - Fast start default, slow start optional
// - Active discharge ramps down on switch-off
// - Peak limit clamps duty, keeps running
// - Mode field: sync, sleep or auto
// - Sleep forced by sleep-on-A or sleep-on-B
// - Full-current bit for first two only
// - Merge ignores second's controls but pulldown
// - Termination mode tracks half reference
// - No-power moves to reset on supply
// - Clock mode on request, loss, powerdown
// - Leave clock mode on supply, key, alarm
// - Enable pins inert in clock mode; select pins still steer sleep
`timescale 1ns/1ns
`default_nettype none
`include "bkrc_regs.svh"
module bkrc_top
    import bkrc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Per-regulator controls, packed four wide
    input wire logic [`BKRC_NCH-1:0] i_enable_bit,
    input wire logic [`BKRC_NCH-1:0] i_seq_enable,
    input wire logic [`BKRC_NCH-1:0] i_gpi_enable_assign,
    input wire logic [`BKRC_NCH-1:0] i_setting_select,
    input wire logic [`BKRC_NCH-1:0] i_gpi_select_assign,
    input wire logic [`BKRC_NCH-1:0] i_auto_select,
    input wire logic [`BKRC_NCH*`BKRC_CW-1:0] i_setting_a_voltage,
    input wire logic [`BKRC_NCH*`BKRC_CW-1:0] i_setting_b_voltage,
    input wire logic [`BKRC_NCH-1:0] i_sleep_on_setting_a,
    input wire logic [`BKRC_NCH-1:0] i_sleep_on_setting_b,
    input wire logic [`BKRC_NCH*2-1:0] i_mode,
    input wire logic [`BKRC_NCH*2-1:0] i_peak_current_limit,
    input wire logic [`BKRC_NCH-1:0] i_pulldown_disable,
    input wire logic i_reg1_full_current,
    input wire logic i_reg2_full_current,
    input wire logic i_dual_phase_merge,
    input wire logic i_termination_mode_enable,
    input wire logic i_termination_ref_out_enable,
    // Shared controls
    input wire logic [`BKRC_STEP_W-1:0] i_step_time,
    input wire logic i_slow_start_enable,
    input wire logic i_active_discharge_enable,
    input wire logic i_auto_clock_mode_from_powerdown,
    input wire logic i_clock_mode_request,
    input wire logic i_powerdown,
    input wire logic i_seq_b_active,
    // Pins and analog comparators
    input wire logic [`BKRC_NCH-1:0] i_gpi_enable_pin,
    input wire logic [`BKRC_NCH-1:0] i_gpi_select_pin,
    input wire logic [`BKRC_NCH-1:0] i_current_over_limit,
    input wire logic i_supply_ok,
    input wire logic i_power_key_n,
    input wire logic i_clock_alarm,
    // Outputs to power stages
    output logic [`BKRC_NCH*`BKRC_CW-1:0] o_voltage_code,
    output logic [`BKRC_NCH-1:0] o_stage_on,
    output logic [`BKRC_NCH-1:0] o_sleep_mode,
    output logic [`BKRC_NCH-1:0] o_auto_mode,
    output logic [`BKRC_NCH-1:0] o_duty_limit,
    output logic [`BKRC_NCH-1:0] o_pulldown_on,
    output logic [`BKRC_NCH*2-1:0] o_peak_current_limit,
    output logic [`BKRC_NCH*`BKRC_CW-1:0] o_step_mv,
    output logic o_reg1_full_current,
    output logic o_reg2_full_current,
    output logic o_termination_track,
    output logic o_termination_reference_out,
    output logic o_memory_supply_sense_pin,
    output logic o_gpio_enabled,
    output logic o_voltage_ready_event,
    output logic [3:0] o_power_mode
);
    // ==================================================
    // Pin synchronisers
    logic [`BKRC_NCH-1:0] gpi_en_s;
    logic [`BKRC_NCH-1:0] gpi_sel_s;
    logic [`BKRC_NCH-1:0] ilim_s;
    logic [2:0] misc_s;
    logic supply_s;
    logic key_n_s;
    logic alarm_s;
    bkrc_sync #(.W(`BKRC_NCH)) u_sync_en (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
        .i_async(i_gpi_enable_pin), .o_sync(gpi_en_s));
    bkrc_sync #(.W(`BKRC_NCH)) u_sync_sel (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
        .i_async(i_gpi_select_pin), .o_sync(gpi_sel_s));
    bkrc_sync #(.W(`BKRC_NCH)) u_sync_ilim (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
        .i_async(i_current_over_limit), .o_sync(ilim_s));
    bkrc_sync #(.W(3)) u_sync_misc (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
        .i_async({i_supply_ok, i_power_key_n, i_clock_alarm}), .o_sync(misc_s));
    assign supply_s = misc_s[2];
    assign key_n_s = misc_s[1];
    assign alarm_s = misc_s[0];

    // ==================================================
    // Power mode machine
    bkrc_pmode_t pmode_reg;
    logic clk_mode;
    assign clk_mode = (pmode_reg == BKRC_CLKMODE);
    // Mode transitions
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pmode_reg <= BKRC_NOPWR;
        end else begin
            unique case (pmode_reg)
                BKRC_NOPWR: begin
                    if (supply_s) begin
                        pmode_reg <= BKRC_RESET;
                    end
                end
                BKRC_RESET: begin
                    if (!supply_s || i_clock_mode_request) begin
                        pmode_reg <= BKRC_CLKMODE;
                    end else begin
                        pmode_reg <= BKRC_ON;
                    end
                end
                BKRC_ON: begin
                    // Supply loss, request, or auto from power-down
                    if (!supply_s || i_clock_mode_request
                        || (i_powerdown && i_auto_clock_mode_from_powerdown)) begin
                        pmode_reg <= BKRC_CLKMODE;
                    end
                end
                BKRC_CLKMODE: begin
                    // Leave only with a supply present to run from
                    if (supply_s && (!key_n_s || alarm_s || !i_clock_mode_request)) begin
                        pmode_reg <= BKRC_ON;
                    end
                end
                default: begin
                    pmode_reg <= BKRC_NOPWR;
                end
            endcase
        end
    end

    // ==================================================
    // Stepping tick shared by all channels
    logic tick;
    logic [`BKRC_STEP_W-1:0] step_eff;
    // Slow start swaps in BKRC_SLOW_STEP for every ramp; otherwise i_step_time is used
    assign step_eff = i_slow_start_enable ? `BKRC_SLOW_STEP : i_step_time;
    bkrc_tick u_tick (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_step_time(step_eff),
        .o_tick(tick)
    );

    // ==================================================
    // Per-channel control
    logic [`BKRC_NCH-1:0] at_target;
    logic [`BKRC_NCH-1:0] ramping;
    genvar g;
    generate
        for (g = 0; g < `BKRC_NCH; g = g + 1) begin : g_ch
            logic [`BKRC_CW-1:0] code_reg;
            logic [`BKRC_CW-1:0] target;
            logic sel_b;
            logic en;
            logic [1:0] mode_f;
            logic ctl_ok;
            // Second channel controls are dropped when merged
            assign ctl_ok = !(i_dual_phase_merge && g == 1);
            // Gpio sources are dead in clock mode
            assign en = ctl_ok && !clk_mode && (i_enable_bit[g] || i_seq_enable[g]
                || (i_gpi_enable_assign[g] && gpi_en_s[g]));
            // Setting selection: pin, then auto from i_seq_b_active, then bit
            assign sel_b = i_gpi_select_assign[g] ? gpi_sel_s[g] :
                i_auto_select[g] ? i_seq_b_active : i_setting_select[g];
            assign target = !en ? `BKRC_CODE_ZERO :
                sel_b ? i_setting_b_voltage[g*`BKRC_CW +: `BKRC_CW] :
                i_setting_a_voltage[g*`BKRC_CW +: `BKRC_CW];
            assign mode_f = i_mode[g*2 +: 2];
            assign at_target[g] = (code_reg == target);
            assign ramping[g] = !at_target[g];
            // Code stepper: one code per tick toward newest target
            always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    code_reg <= `BKRC_CODE_ZERO;
                end else if (!en && !i_active_discharge_enable) begin
                    code_reg <= `BKRC_CODE_ZERO;
                end else if (tick && !at_target[g]) begin
                    if (code_reg < target) begin
                        code_reg <= code_reg + `BKRC_CW'(1);
                    end else begin
                        code_reg <= code_reg - `BKRC_CW'(1);
                    end
                end
            end
            // Stage drive and mode outputs
            always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    o_voltage_code[g*`BKRC_CW +: `BKRC_CW] <= `BKRC_CODE_ZERO;
                    o_stage_on[g] <= 1'b0;
                    o_sleep_mode[g] <= 1'b0;
                    o_auto_mode[g] <= 1'b0;
                    o_duty_limit[g] <= 1'b0;
                    o_pulldown_on[g] <= 1'b0;
                    o_peak_current_limit[g*2 +: 2] <= 2'h0;
                    o_step_mv[g*`BKRC_CW +: `BKRC_CW] <= `BKRC_STEP_MV_STD;
                end else begin
                    o_voltage_code[g*`BKRC_CW +: `BKRC_CW] <= code_reg;
                    // Stage stays on while discharging down the ramp
                    o_stage_on[g] <= en || (code_reg != `BKRC_CODE_ZERO);
                    o_sleep_mode[g] <= ctl_ok && ((mode_f == `BKRC_MODE_SLEEP)
                        || (sel_b ? i_sleep_on_setting_b[g] : i_sleep_on_setting_a[g]));
                    o_auto_mode[g] <= ctl_ok && (mode_f == `BKRC_MODE_AUTO);
                    // Over-limit only clamps duty; no shutdown path exists
                    o_duty_limit[g] <= ilim_s[g];
                    // Pulldown disable is honoured even when merged
                    o_pulldown_on[g] <= !i_pulldown_disable[g] && !en;
                    o_peak_current_limit[g*2 +: 2] <= ctl_ok ?
                        i_peak_current_limit[g*2 +: 2] : 2'h0;
                    o_step_mv[g*`BKRC_CW +: `BKRC_CW] <= (g == `BKRC_THIRD_IDX) ?
                        `BKRC_STEP_MV_THIRD : `BKRC_STEP_MV_STD;
                end
            end
        end
    endgenerate

    // ==================================================
    // Ready event after a ramp completes on every channel
    logic any_ramp_reg;
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            any_ramp_reg <= 1'b0;
            o_voltage_ready_event <= 1'b0;
        end else begin
            any_ramp_reg <= |ramping;
            o_voltage_ready_event <= any_ramp_reg && (&at_target);
        end
    end

    // ==================================================
    // Current mode, termination and pin reuse
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reg1_full_current <= 1'b0;
            o_reg2_full_current <= 1'b0;
            o_termination_track <= 1'b0;
            o_termination_reference_out <= 1'b0;
            o_memory_supply_sense_pin <= 1'b0;
            o_gpio_enabled <= 1'b0;
            o_power_mode <= BKRC_NOPWR;
        end else begin
            o_reg1_full_current <= i_reg1_full_current;
            o_reg2_full_current <= i_reg2_full_current && !i_dual_phase_merge;
            // Termination relies on the host forcing sync mode
            o_termination_track <= i_termination_mode_enable;
            o_termination_reference_out <= i_termination_ref_out_enable;
            // The buffered reference needs the memory supply, so either bit claims it
            o_memory_supply_sense_pin <= i_termination_mode_enable
                || i_termination_ref_out_enable;
            o_gpio_enabled <= !clk_mode;
            o_power_mode <= pmode_reg;
        end
    end
endmodule
`default_nettype wire

// ---- verif/bkrc_chk.sv ----
/* Checker for bkrc_top: step size, ramps, ready event, power modes.
   Assumes it is bound into bkrc_top and sees one core clock domain. */
`timescale 1ns/1ns
`default_nettype none
module bkrc_chk
    import bkrc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [3:0] i_setting_select,
    input wire logic [3:0] i_gpi_select_assign,
    input wire logic [3:0] i_auto_select,
    input wire logic [3:0] i_sleep_on_setting_a,
    input wire logic i_termination_mode_enable,
    input wire logic i_termination_ref_out_enable,
    input wire logic [31:0] o_voltage_code,
    input wire logic [3:0] o_stage_on,
    input wire logic [3:0] o_sleep_mode,
    input wire logic [31:0] o_step_mv,
    input wire logic o_termination_track,
    input wire logic o_termination_reference_out,
    input wire logic o_gpio_enabled,
    input wire logic o_voltage_ready_event,
    input wire logic [3:0] o_power_mode
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    // ==========
    // Sequences
    // Channel 0 running on both cycles and its code moved
    sequence moved0;
        o_stage_on[0] && $past(o_stage_on[0]) && o_voltage_code[7:0] != $past(o_voltage_code[7:0]);
    endsequence
    // Setting A held active with sleep-on-A set, stage running
    sequence sel_a_sleep;
        (i_sleep_on_setting_a[0] && !i_setting_select[0] && !i_gpi_select_assign[0]
            && !i_auto_select[0] && o_stage_on[0]) [*3];
    endsequence
    // ==========
    // Assertions
    step_size_a: assert property (!$past(i_sys_rst) |-> o_step_mv == {8'h0a, 8'h14, 8'h0a, 8'h0a})
        else $error("step size wrong");
    ramp_step_a: assert property (moved0 |->
        o_voltage_code[7:0] - $past(o_voltage_code[7:0]) == 8'h01
        || $past(o_voltage_code[7:0]) - o_voltage_code[7:0] == 8'h01)
        else $error("ramp skipped a code");
    ready_once_a: assert property (o_voltage_ready_event |=>
        $stable(o_voltage_code) && !o_voltage_ready_event)
        else $error("ready event while moving or too long");
    sleep_on_a_a: assert property (sel_a_sleep |-> o_sleep_mode[0])
        else $error("sleep not forced on setting A");
    nopower_exit_a: assert property ($past(o_power_mode) == BKRC_NOPWR
        && o_power_mode != BKRC_NOPWR |-> o_power_mode == BKRC_RESET)
        else $error("no-power left other than to reset");
    supplies_off_a: assert property ((o_power_mode == BKRC_CLKMODE) [*2] |-> o_stage_on == 4'h0)
        else $error("stage on in clock mode");
    pins_off_a: assert property ($rose(o_power_mode[3]) ##1 o_power_mode[3] |-> !o_gpio_enabled)
        else $error("pins live in clock mode");
    term_track_a: assert property ((i_termination_mode_enable
        && o_power_mode == BKRC_ON) [*3] |-> o_termination_track)
        else $error("termination not tracking");
    ref_out_a: assert property ((i_termination_mode_enable && i_termination_ref_out_enable
        && o_power_mode == BKRC_ON) [*3] |-> o_termination_reference_out)
        else $error("reference not buffered out");
endmodule
`default_nettype wire

// ---- verif/bkrc_stage_model.sv ----
/* Model of the power stages: current comparators and supply monitor.
   Assumes the bench commands overload and supply presence. */
`timescale 1ns/1ns
`default_nettype none
module bkrc_stage_model (
    input wire logic i_core_clk,
    input wire logic [3:0] i_stage_on,
    input wire logic [3:0] i_overload,
    input wire logic i_supply_on,
    output var logic [3:0] o_over_limit = 4'h0,
    output var logic o_supply_ok = 1'b1
);
    // Comparator trips only on a switching stage; an idle stage draws nothing
    always @(posedge i_core_clk) begin
        o_over_limit <= i_overload & i_stage_on;
        o_supply_ok <= i_supply_on;
    end
endmodule
`default_nettype wire

// ---- verif/tb_bkrc_top.sv ----
/* Bench for bkrc_top: power-up, ramps, enables, settings, clock mode.
   Assumes bkrc_chk and bkrc_stage_model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tb_bkrc_top;
    logic clk = 1'b0, rst = 1'b1;
    logic [3:0] en = 4'h0, seqe = 4'h0, gpea = 4'h0, sel = 4'h0, gpsa = 4'h0, asel = 4'h0;
    logic [3:0] sla = 4'h0, slb = 4'h0, pdd = 4'h0, gpep = 4'h0, gpsp = 4'h0, ovl = 4'h0;
    logic [31:0] va = 32'h0, vb = 32'h0;
    logic [7:0] mode = 8'haa, ilim = 8'h1b;
    logic fc1 = 1'b0, fc2 = 1'b0, mrg = 1'b0, tme = 1'b0, tre = 1'b0, sse = 1'b0, ade = 1'b0;
    logic acm = 1'b0, cmr = 1'b0, pwd = 1'b0, sba = 1'b0, sup = 1'b1, key_n = 1'b1, alm = 1'b0;
    logic [3:0] stt = 4'h0;
    logic [3:0] son, slp, aut, dl, pdo, col, pm;
    logic [31:0] code, smv;
    logic [7:0] ilo;
    logic fo1, fo2, trk, tro, mss, gpo, rdy, sok;
    int miscompares = 0, comparisons = 0;
    bkrc_stage_model mdl_u (.i_core_clk(clk), .i_stage_on(son), .i_overload(ovl),
        .i_supply_on(sup), .o_over_limit(col), .o_supply_ok(sok));
    bkrc_top dut_u (.i_core_clk(clk), .i_sys_rst(rst), .i_enable_bit(en), .i_seq_enable(seqe),
        .i_gpi_enable_assign(gpea), .i_setting_select(sel), .i_gpi_select_assign(gpsa),
        .i_auto_select(asel), .i_setting_a_voltage(va), .i_setting_b_voltage(vb),
        .i_sleep_on_setting_a(sla), .i_sleep_on_setting_b(slb), .i_mode(mode),
        .i_peak_current_limit(ilim), .i_pulldown_disable(pdd), .i_reg1_full_current(fc1),
        .i_reg2_full_current(fc2), .i_dual_phase_merge(mrg), .i_termination_mode_enable(tme),
        .i_termination_ref_out_enable(tre), .i_step_time(stt), .i_slow_start_enable(sse),
        .i_active_discharge_enable(ade), .i_auto_clock_mode_from_powerdown(acm),
        .i_clock_mode_request(cmr), .i_powerdown(pwd), .i_seq_b_active(sba),
        .i_gpi_enable_pin(gpep), .i_gpi_select_pin(gpsp), .i_current_over_limit(col),
        .i_supply_ok(sok), .i_power_key_n(key_n), .i_clock_alarm(alm), .o_voltage_code(code),
        .o_stage_on(son), .o_sleep_mode(slp), .o_auto_mode(aut), .o_duty_limit(dl),
        .o_pulldown_on(pdo), .o_peak_current_limit(ilo), .o_step_mv(smv),
        .o_reg1_full_current(fo1), .o_reg2_full_current(fo2), .o_termination_track(trk),
        .o_termination_reference_out(tro), .o_memory_supply_sense_pin(mss),
        .o_gpio_enabled(gpo), .o_voltage_ready_event(rdy), .o_power_mode(pm));
    // ==========
    // Helpers; inputs always move 1 ns after the edge
    always #25 clk = ~clk;
    task tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // A wait that ran out ends the run at once
    task wt(input logic ok, input string m);
        chk(ok, m);
        if (ok !== 1'b1) report_and_stop();
    endtask
    task wpm(input logic [3:0] m);
        int i;
        for (i = 0; i < 30 && pm !== m; i++) tk(1);
        wt(pm === m, "power mode");
    endtask
    // Follow one channel's ramp to its target and the ready pulse
    task watch(input int ch, input logic [7:0] tgt, input int per);
        logic [7:0] prev, d;
        int i, last;
        logic seen;
        prev = code[ch*8+:8];
        last = 0;
        seen = 1'b0;
        for (i = 1; i < 3000 && !seen; i++) begin
            tk(1);
            d = code[ch*8+:8];
            if (d !== prev) begin
                chk(tgt > prev ? d === prev + 8'h01 : d === prev - 8'h01, "ramp step");
                if (per > 0 && last > 0) chk(i - last == per, "step time");
                last = i;
                prev = d;
            end
            seen = rdy === 1'b1 && prev === tgt;
        end
        wt(seen, "ready event");
    endtask
    // ==========
    // Scenarios
    task t_ramp();
        int i;
        en[0] = 1'b1;
        va[7:0] = 8'h03;
        watch(0, 8'h03, 0);
        stt = 4'h1;
        va[7:0] = 8'h08;
        for (i = 0; i < 400 && code[7:0] !== 8'h05; i++) tk(1);
        wt(code[7:0] === 8'h05, "mid ramp");
        va[7:0] = 8'h02;
        watch(0, 8'h02, 40);
        ade = 1'b1;
        en[0] = 1'b0;
        watch(0, 8'h00, 40);
        {ade, sse, en[2]} = 3'b011;
        va[23:16] = 8'h02;
        watch(2, 8'h02, 100);
        {sse, en[2]} = 2'b00;
        $display("ramp test done");
    endtask
    task t_enable();
        int s, i;
        for (s = 0; s < 3; s++) begin
            {en[1], seqe[1], gpea[1], gpep[1]} = {s == 0, s == 1, s == 2, 1'b1};
            for (i = 0; i < 8 && son[1] !== 1'b1; i++) tk(1);
            wt(son[1] === 1'b1, "enable source");
            {en[1], seqe[1], gpea[1]} = 3'b000;
            tk(6);
            chk(son[1] === 1'b0, "unassigned pin");
        end
        {mrg, en[1], fc2} = 3'b111;
        tk(6);
        chk(son[1] === 1'b0 && fo2 === 1'b0 && pdo[1] === 1'b1, "merged controls");
        pdd[1] = 1'b1;
        tk(2);
        chk(pdo[1] === 1'b0, "merged pulldown disable");
        {mrg, en[1], fc2, pdd[1]} = 4'b0000;
        $display("enable test done");
    endtask
    task t_mode();
        static logic [4:0] rows [5] = '{5'b10001, 5'b00000, 5'b01001, 5'b00111, 5'b00100};
        int m;
        {en[0], slb[0], gpsp[0]} = 3'b111;
        for (m = 0; m < 3; m++) begin
            mode[1:0] = m[1:0];
            tk(4);
            chk(slp[0] === (m == 1) && aut[0] === (m == 0), "mode field");
        end
        for (m = 0; m < 5; m++) begin
            {sel[0], gpsa[0], asel[0], sba} = rows[m][4:1];
            tk(4);
            chk(slp[0] === rows[m][0], "sleep on B");
        end
        {sla[0], slb[0], asel[0]} = 3'b100;
        tk(4);
        chk(slp[0] === 1'b1, "sleep on A");
        {sla[0], ovl[0]} = 2'b01;
        tk(6);
        chk(dl[0] === 1'b1 && son[0] === 1'b1 && ilo === ilim, "current limit");
        ovl[0] = 1'b0;
        for (m = 0; m < 4; m++) begin
            {fc1, fc2} = m[1:0];
            tk(3);
            chk(fo1 === m[1] && fo2 === m[0], "full current");
        end
        $display("mode test done");
    endtask
    task t_term();
        int v;
        mode[7:6] = 2'h2;
        en[3] = 1'b1;
        for (v = 0; v < 4; v++) begin
            {tme, tre} = v[1:0];
            tk(4);
            chk(trk === v[1], "termination track");
            chk(tro === v[0] && mss === (v != 0), "termination pins");
        end
        {tme, tre, en[3]} = 3'b000;
        $display("termination test done");
    endtask
    task t_clock();
        int s;
        cmr = 1'b1;
        wpm(4'h8);
        tk(2);
        chk(son === 4'h0 && gpo === 1'b0, "clock mode outputs");
        cmr = 1'b0;
        wpm(4'h4);
        sup = 1'b0;
        wpm(4'h8);
        sup = 1'b1;
        wpm(4'h4);
        for (s = 0; s < 2; s++) begin
            cmr = 1'b1;
            wpm(4'h8);
            {key_n, alm} = {s != 0, s == 1};
            wpm(4'h4);
            {cmr, key_n, alm} = 3'b010;
            wpm(4'h4);
        end
        {acm, pwd} = 2'b11;
        wpm(4'h8);
        {acm, pwd} = 2'b00;
        wpm(4'h4);
        $display("clock mode test done");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1;
        chk(pm === 4'h1, "no power in reset");
        rst = 1'b0;
        wpm(4'h2);
        wpm(4'h4);
        chk(smv === {8'h0a, 8'h14, 8'h0a, 8'h0a}, "step size");
        $display("power-up test done");
        t_ramp();
        t_enable();
        t_mode();
        t_term();
        t_clock();
        report_and_stop();
    end
endmodule
bind bkrc_top bkrc_chk chk_u (.i_core_clk, .i_sys_rst, .i_setting_select, .i_gpi_select_assign,
    .i_auto_select, .i_sleep_on_setting_a, .i_termination_mode_enable,
    .i_termination_ref_out_enable, .o_voltage_code, .o_stage_on, .o_sleep_mode, .o_step_mv,
    .o_termination_track, .o_termination_reference_out, .o_gpio_enabled,
    .o_voltage_ready_event, .o_power_mode);
`default_nettype wire
